// file: design/fppr_fuse_program.sv
// Behaviour
// - pulse width codes bit: short zero, long one
// - 38-bit word: start, fn, param, dummy, value, end
// - param selects gain2, gain1, offset, lock/check fuses
// - volatile values while unlocked, fuses once locked
// - unblown fuse reads zero, blown reads one
// - program: function 10, one-hot value picks fuse
// - blow switch on valid word, off when broken
// - fuses rule only after lock; simulation ignored
// - lock fuse via param 11 value 1; then reject
// - twenty fuses: 18 code, lock, check
// - xor sum of all 18 code bits
// - two-input xor stage after the sum
// - parity error zero while unlocked
// - parity error forces amplifier output low
// - read: function 11, value field ignored
// - read entry loads 8-bit register, drives msb
// - each of the first seven pulse falling edges shifts, msb first
// - eighth pulse ends read, releases pin
// - short values zero padded at top
// - readback bit also on amplifier output
//
// Our own choices: the address map and the APB register port.
module fppr_fuse_program #(
    parameter int W1_CYCLES = fppr_pkg::T_W1_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fppr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // single-wire programming input
    input wire logic pulse_serial_input,
    // fuse array sense and blow switch
    input wire logic [fppr_pkg::FUSE_N-1:0] fuse_sense,
    output logic fuse_blow_en,
    output logic [4:0] fuse_blow_index,
    // readback pin
    output logic filter_readback_pin,
    output logic filter_readback_oe_n,
    // amplifier control
    output fppr_pkg::fppr_codes_t active_codes,
    output logic amp_force_low,
    output logic amp_digital_en,
    output logic amp_digital_bit,
    // check status
    output logic lock_fuse_state,
    output logic check_fuse_state,
    output logic code_xor_sum,
    output logic combined_check_result,
    output logic parity_error
);

    fppr_pkg::fppr_state_t st; // registered state
    fppr_pkg::fppr_state_t next_st; // next state
    fppr_pkg::fppr_codes_t fuse_codes; // codes held in fuses
    logic fall; // falling edge of the input
    logic bit_ok; // pulse long enough to count
    logic bit_val; // decoded bit value
    logic frame_ok; // start, dummy and end all match
    logic [1:0] fn; // function field
    logic [1:0] par; // parameter field
    logic [7:0] val; // value field
    logic [7:0] fused_val; // fused value of selected parameter
    logic [2:0] pos; // position of the set value bit
    logic idx_ok; // value picks a real fuse
    logic [4:0] idx; // fuse picked by the value
    logic prog_ok; // word asks for a legal blow
    logic rd_enter; // word enters read mode
    logic setup; // apb setup cycle
    logic access_wr; // apb write completing
    logic mapped; // address hits a register
    logic [31:0] rd_mux; // read data selected by address

    // fuse array read out; an intact fuse senses as zero
    assign fuse_codes.gain2 =
        fuse_sense[fppr_pkg::FUSE_GAIN2_LSB +: fppr_pkg::GAIN2_W];
    assign fuse_codes.gain1 =
        fuse_sense[fppr_pkg::FUSE_GAIN1_LSB +: fppr_pkg::GAIN1_W];
    assign fuse_codes.offset =
        fuse_sense[fppr_pkg::FUSE_OFFSET_LSB +: fppr_pkg::OFFSET_W];
    assign lock_fuse_state = fuse_sense[fppr_pkg::FUSE_LOCK];
    assign check_fuse_state = fuse_sense[fppr_pkg::FUSE_CHECK];

    // active codes: volatile until locked, fuses afterwards
    assign active_codes =
        lock_fuse_state ? fuse_codes : st.sim;

    // parity path
    assign code_xor_sum = ^active_codes;
    assign combined_check_result =
        code_xor_sum ^ check_fuse_state;
    assign parity_error = lock_fuse_state & combined_check_result;
    assign amp_force_low = parity_error;

    // readback pin and amplifier digital path
    assign filter_readback_pin = st.rd_active & st.rd_sr[7];
    assign filter_readback_oe_n = ~st.rd_active;
    assign amp_digital_en = st.rd_active;
    assign amp_digital_bit = filter_readback_pin;

    // blow switch and bus outputs
    assign fuse_blow_en = st.blow_en;
    assign fuse_blow_index = st.blow_idx;
    assign prdata = st.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & st.err;

    // pulse width decode at the falling edge
    assign fall = st.in_prev & ~pulse_serial_input;
    assign bit_ok = fall &&
        (st.width >= fppr_pkg::CNT_W'(fppr_pkg::T_W0_MIN_CYC));
    assign bit_val = (st.width >= fppr_pkg::CNT_W'(W1_CYCLES));

    // field split of the shifted word
    assign fn = st.word[fppr_pkg::FN_LSB +: 2];
    assign par = st.word[fppr_pkg::PAR_LSB +: 2];
    assign val = st.word[fppr_pkg::VAL_LSB +: 8];
    assign frame_ok =
        (st.word[fppr_pkg::START_LSB +: 12] == fppr_pkg::START_PAT) &&
        (st.word[fppr_pkg::DUMMY_LSB +: 2] == fppr_pkg::DUMMY_PAT) &&
        (st.word[fppr_pkg::END_LSB +: 12] == fppr_pkg::END_PAT);

    // fused value of the chosen parameter, zero padded on top
    always_comb begin
        case (par)
            fppr_pkg::PAR_GAIN2: fused_val = {5'h00, fuse_codes.gain2};
            fppr_pkg::PAR_GAIN1: fused_val = {1'h0, fuse_codes.gain1};
            fppr_pkg::PAR_OFFSET: fused_val = fuse_codes.offset;
            default: begin
                fused_val = 8'h00;
                fused_val[fppr_pkg::OTHER_LOCK_BIT] = lock_fuse_state;
                fused_val[fppr_pkg::OTHER_CHECK_BIT] = check_fuse_state;
            end
        endcase
    end

    // map a one-hot value onto a fuse index
    always_comb begin
        pos = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (val[i]) begin
                pos = 3'(i);
            end
        end
        idx = 5'h00;
        idx_ok = 1'b0;
        case (par)
            fppr_pkg::PAR_GAIN2: begin
                idx_ok = (pos < 3'(fppr_pkg::GAIN2_W));
                idx = 5'(fppr_pkg::FUSE_GAIN2_LSB) + {2'h0, pos};
            end
            fppr_pkg::PAR_GAIN1: begin
                idx_ok = (pos < 3'(fppr_pkg::GAIN1_W));
                idx = 5'(fppr_pkg::FUSE_GAIN1_LSB) + {2'h0, pos};
            end
            fppr_pkg::PAR_OFFSET: begin
                idx_ok = 1'b1;
                idx = 5'(fppr_pkg::FUSE_OFFSET_LSB) + {2'h0, pos};
            end
            default: begin
                if (pos == 3'(fppr_pkg::OTHER_LOCK_BIT)) begin
                    idx_ok = 1'b1;
                    idx = 5'(fppr_pkg::FUSE_LOCK);
                end else if (pos == 3'(fppr_pkg::OTHER_CHECK_BIT)) begin
                    idx_ok = 1'b1;
                    idx = 5'(fppr_pkg::FUSE_CHECK);
                end
            end
        endcase
    end

    // decoded commands
    assign prog_ok = frame_ok && (fn == fppr_pkg::FN_PROGRAM) &&
        $onehot(val) && idx_ok && !lock_fuse_state &&
        !st.rd_active;
    assign rd_enter = st.shifted && frame_ok &&
        (fn == fppr_pkg::FN_READ) && !st.rd_active;

    // apb decode
    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pwrite & ~st.err;
    assign mapped = (paddr == fppr_pkg::REG_SIM_GAIN2) ||
        (paddr == fppr_pkg::REG_SIM_GAIN1) ||
        (paddr == fppr_pkg::REG_SIM_OFFSET) ||
        (paddr == fppr_pkg::REG_STATUS) ||
        (paddr == fppr_pkg::REG_ACTIVE) ||
        (paddr == fppr_pkg::REG_FUSES);

    // read data mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            fppr_pkg::REG_SIM_GAIN2: rd_mux[2:0] = st.sim.gain2;
            fppr_pkg::REG_SIM_GAIN1: rd_mux[6:0] = st.sim.gain1;
            fppr_pkg::REG_SIM_OFFSET: rd_mux[7:0] = st.sim.offset;
            fppr_pkg::REG_STATUS: begin
                rd_mux[fppr_pkg::STAT_LOCK] = lock_fuse_state;
                rd_mux[fppr_pkg::STAT_CHECK] = check_fuse_state;
                rd_mux[fppr_pkg::STAT_XOR] = code_xor_sum;
                rd_mux[fppr_pkg::STAT_COMBINED] = combined_check_result;
                rd_mux[fppr_pkg::STAT_PERR] = parity_error;
                rd_mux[fppr_pkg::STAT_READ] = st.rd_active;
                rd_mux[fppr_pkg::STAT_BLOW] = st.blow_en;
            end
            fppr_pkg::REG_ACTIVE: rd_mux[17:0] = active_codes;
            fppr_pkg::REG_FUSES: rd_mux[19:0] = fuse_sense;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // next state
    always_comb begin
        next_st = st;
        next_st.in_prev = pulse_serial_input;
        // width counter runs while high, saturates
        if (!pulse_serial_input) begin
            next_st.width = '0;
        end else if (st.width != '1) begin
            next_st.width = st.width + fppr_pkg::CNT_W'(1);
        end
        // shift decoded bit in, first bit ends at the top
        next_st.shifted = bit_ok;
        if (bit_ok) begin
            next_st.word = {st.word[fppr_pkg::WORD_W-2:0], bit_val};
        end
        // blow switch follows the live word
        next_st.blow_en = prog_ok;
        if (prog_ok) begin
            next_st.blow_idx = idx;
        end
        // read mode
        if (rd_enter) begin
            next_st.rd_active = 1'b1;
            next_st.rd_sr = fused_val;
            next_st.rd_cnt = 3'h0;
        end else if (st.rd_active && bit_ok) begin
            if (st.rd_cnt == 3'h7) begin
                next_st.rd_active = 1'b0;
            end else begin
                next_st.rd_sr = {st.rd_sr[6:0], 1'b0};
                next_st.rd_cnt = st.rd_cnt + 3'h1;
            end
        end
        // apb setup captures read data and error
        if (setup) begin
            next_st.prdata = rd_mux;
            next_st.err = ~mapped;
        end
        // volatile code writes, ignored once locked
        if (access_wr && !lock_fuse_state) begin
            case (paddr)
                fppr_pkg::REG_SIM_GAIN2: next_st.sim.gain2 = pwdata[2:0];
                fppr_pkg::REG_SIM_GAIN1: next_st.sim.gain1 = pwdata[6:0];
                fppr_pkg::REG_SIM_OFFSET: next_st.sim.offset = pwdata[7:0];
                default: next_st.sim = st.sim;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.sim.gain2 <= fppr_pkg::RST_CODE[2:0];
            st.sim.gain1 <= fppr_pkg::RST_CODE[6:0];
            st.sim.offset <= fppr_pkg::RST_CODE;
        end else begin
            st <= next_st;
        end
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_read_fall;
        st.rd_active && bit_ok;
    endsequence

    sequence s_last_pulse;
        s_read_fall ##0 (st.rd_cnt == 3'h7);
    endsequence

    long_pulse_one_a: assert property (
        bit_ok && (st.width >= fppr_pkg::CNT_W'(W1_CYCLES)) |=> st.word[0])
        else $error("long pulse not decoded as one");
    fuse_codes_rule_a: assert property (
        lock_fuse_state |-> active_codes == fuse_sense[17:0])
        else $error("locked codes not from fuses");
    sim_codes_rule_a: assert property (
        !lock_fuse_state |-> active_codes == st.sim)
        else $error("unlocked codes not volatile");
    xor_sum_value_a: assert property (
        lock_fuse_state |-> code_xor_sum == ^fuse_sense[17:0])
        else $error("code xor sum wrong");
    perr_gated_a: assert property (
        parity_error |-> lock_fuse_state &&
        (^fuse_sense[17:0] != check_fuse_state))
        else $error("parity error without lock or mismatch");
    force_low_a: assert property (
        amp_force_low == (lock_fuse_state &&
        (^fuse_sense[17:0] != check_fuse_state)))
        else $error("amplifier not forced low on parity error");
    blow_locked_a: assert property (
        $rose(fuse_blow_en) |-> !$past(lock_fuse_state))
        else $error("blow after lock");
    blow_release_a: assert property (
        fuse_blow_en && !frame_ok |=> !fuse_blow_en)
        else $error("blow switch not released");
    read_entry_a: assert property (
        rd_enter |=> st.rd_active &&
        filter_readback_pin == $past(fused_val[7]))
        else $error("read entry did not drive msb");
    read_shift_a: assert property (
        s_read_fall ##0 (st.rd_cnt != 3'h7) |=>
        filter_readback_pin == $past(st.rd_sr[6]))
        else $error("read shift wrong");
    read_end_a: assert property (
        s_last_pulse |=> !st.rd_active ##0 filter_readback_oe_n)
        else $error("read not ended on eighth pulse");
    pad_zero_a: assert property (
        rd_enter && par == fppr_pkg::PAR_GAIN2 |=> st.rd_sr[7:3] == 5'h00)
        else $error("short value not zero padded");
    amp_copy_a: assert property (
        st.rd_active |-> amp_digital_en &&
        amp_digital_bit == st.rd_sr[7])
        else $error("readback bit missing on amplifier");
    short_pulse_skip_a: assert property (
        fall && (st.width < fppr_pkg::CNT_W'(fppr_pkg::T_W0_MIN_CYC)) |=>
        $stable(st.word))
        else $error("short pulse shifted a bit");
    blow_onehot_a: assert property (
        $rose(fuse_blow_en) |-> $past(fn == fppr_pkg::FN_PROGRAM) &&
        $onehot($past(val)))
        else $error("blow without one-hot program word");

endmodule

// file: design/fppr_pkg.sv
package fppr_pkg;

    // clock rate and pulse width timing
    localparam int CLK_MHZ = 200;
    localparam int T_W0_MIN_NS = 50;
    localparam int T_W0_MIN_CYC = (T_W0_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int T_W1_US = 50;
    localparam int T_W1_CYC = T_W1_US * CLK_MHZ;
    localparam int CNT_W = 14;

    // serial word layout, bit 37 arrives first
    localparam int WORD_W = 38;
    localparam int START_LSB = 26;
    localparam int FN_LSB = 24;
    localparam int PAR_LSB = 22;
    localparam int DUMMY_LSB = 20;
    localparam int VAL_LSB = 12;
    localparam int END_LSB = 0;
    localparam logic [11:0] START_PAT = 12'h801;
    localparam logic [11:0] END_PAT = 12'h7FE;
    localparam logic [1:0] DUMMY_PAT = 2'h2;

    // function and parameter codes
    localparam logic [1:0] FN_PROGRAM = 2'h2;
    localparam logic [1:0] FN_READ = 2'h3;
    localparam logic [1:0] PAR_GAIN2 = 2'h0;
    localparam logic [1:0] PAR_GAIN1 = 2'h1;
    localparam logic [1:0] PAR_OFFSET = 2'h2;
    localparam logic [1:0] PAR_OTHER = 2'h3;
    localparam int OTHER_LOCK_BIT = 0;
    localparam int OTHER_CHECK_BIT = 2;

    // fuse array map
    localparam int FUSE_N = 20;
    localparam int GAIN2_W = 3;
    localparam int GAIN1_W = 7;
    localparam int OFFSET_W = 8;
    localparam int FUSE_GAIN2_LSB = 0;
    localparam int FUSE_GAIN1_LSB = 3;
    localparam int FUSE_OFFSET_LSB = 10;
    localparam int FUSE_LOCK = 18;
    localparam int FUSE_CHECK = 19;

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_SIM_GAIN2 = 8'h00;
    localparam logic [7:0] REG_SIM_GAIN1 = 8'h04;
    localparam logic [7:0] REG_SIM_OFFSET = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_ACTIVE = 8'h10;
    localparam logic [7:0] REG_FUSES = 8'h14;

    // status field positions
    localparam int STAT_LOCK = 0;
    localparam int STAT_CHECK = 1;
    localparam int STAT_XOR = 2;
    localparam int STAT_COMBINED = 3;
    localparam int STAT_PERR = 4;
    localparam int STAT_READ = 5;
    localparam int STAT_BLOW = 6;

    // reset values
    localparam logic [7:0] RST_CODE = 8'h00;

    // the three amplifier codes
    typedef struct packed {
        logic [OFFSET_W-1:0] offset;
        logic [GAIN1_W-1:0] gain1;
        logic [GAIN2_W-1:0] gain2;
    } fppr_codes_t;

    // whole state of the block
    typedef struct packed {
        logic in_prev;
        logic [CNT_W-1:0] width;
        logic [WORD_W-1:0] word;
        logic shifted;
        logic blow_en;
        logic [4:0] blow_idx;
        logic rd_active;
        logic [7:0] rd_sr;
        logic [2:0] rd_cnt;
        fppr_codes_t sim;
        logic [31:0] prdata;
        logic err;
    } fppr_state_t;

endpackage

// file: tb/fppr_prog_model.sv
// programmer and fuse array standing outside the block
module fppr_prog_model #(
    parameter int W1 = 40,
    parameter int BLOW = 30
) (
    // clock
    input wire logic pclk,
    // single-wire line toward the block
    output logic pulse_serial_input,
    // fuse array side
    input wire logic fuse_blow_en,
    input wire logic [4:0] fuse_blow_index,
    output logic [fppr_pkg::FUSE_N-1:0] fuse_sense
);
    timeunit 1ns;
    timeprecision 100ps;

    int blow_cnt; // cycles the blow switch has been closed

    // line idles low, every fuse intact at power up
    initial begin
        pulse_serial_input = 1'b0;
        fuse_sense = 20'h0;
        blow_cnt = 0;
    end

    // one pulse: long high for one, short high for zero, then a gap
    task pulse(input logic b);
        @(posedge pclk);
        pulse_serial_input <= 1'b1;
        repeat (b ? W1 + 5 : 12) @(posedge pclk);
        pulse_serial_input <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // whole word, one fuse at most per word, msb first
    task send_word(input logic [1:0] fn, input logic [1:0] par,
                   input logic [7:0] val);
        logic [37:0] w;
        int i;
        w = {fppr_pkg::START_PAT, fn, par, fppr_pkg::DUMMY_PAT, val,
             fppr_pkg::END_PAT};
        for (i = 37; i >= 0; i--) begin
            pulse(w[i]);
        end
    endtask

    // a fuse opens after the switch stays closed long enough
    always @(posedge pclk) begin
        if (fuse_blow_en) begin
            blow_cnt <= blow_cnt + 1;
            if (blow_cnt == BLOW) begin
                fuse_sense[fuse_blow_index] <= 1'b1;
            end
        end else begin
            blow_cnt <= 0;
        end
    end

    // spike too short to count as a bit, then a gap
    task glitch;
        @(posedge pclk);
        pulse_serial_input <= 1'b1;
        repeat (4) @(posedge pclk);
        pulse_serial_input <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // stored bit decays to one, only when the bench asks
    task corrupt(input int idx);
        @(posedge pclk);
        fuse_sense[idx] <= 1'b1;
    endtask
endmodule

// file: tb/testbench.sv
// top of the bench: apb tasks, serial words and fuse checks
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int W1 = 40; // shortened long-pulse width
    localparam int BLOW = 30; // shortened blow time

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pulse_serial_input, fuse_blow_en;
    logic [19:0] fuse_sense;
    logic [4:0] fuse_blow_index;
    logic filter_readback_pin, filter_readback_oe_n;
    fppr_pkg::fppr_codes_t active_codes;
    logic amp_force_low, amp_digital_en, amp_digital_bit;
    logic lock_fuse_state, check_fuse_state, code_xor_sum;
    logic combined_check_result, parity_error;
    int error_cnt = 0;
    int tests_run = 0;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    fppr_fuse_program #(.W1_CYCLES(W1)) u_fppr_fuse_program (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulse_serial_input(pulse_serial_input),
        .fuse_sense(fuse_sense), .fuse_blow_en(fuse_blow_en),
        .fuse_blow_index(fuse_blow_index),
        .filter_readback_pin(filter_readback_pin),
        .filter_readback_oe_n(filter_readback_oe_n),
        .active_codes(active_codes), .amp_force_low(amp_force_low),
        .amp_digital_en(amp_digital_en),
        .amp_digital_bit(amp_digital_bit),
        .lock_fuse_state(lock_fuse_state),
        .check_fuse_state(check_fuse_state),
        .code_xor_sum(code_xor_sum),
        .combined_check_result(combined_check_result),
        .parity_error(parity_error));

    fppr_prog_model #(.W1(W1), .BLOW(BLOW)) prog (
        .pclk(pclk), .pulse_serial_input(pulse_serial_input),
        .fuse_blow_en(fuse_blow_en), .fuse_blow_index(fuse_blow_index),
        .fuse_sense(fuse_sense));

    // counts, verdict and end of run
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // single compare for every result
    task check(input string what, input logic [31:0] exp,
               input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, setup then access until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            print_verdict;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // register read with expected data and error flag
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check("read data", exp, q);
        check("slave error", 32'(eerr), 32'(e));
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    // accepted program word, then the blow wait
    task blow(input logic [1:0] par, input logic [7:0] val,
              input logic [4:0] idx);
        prog.send_word(fppr_pkg::FN_PROGRAM, par, val);
        @(negedge pclk);
        check("blow enable", 32'h1, 32'(fuse_blow_en));
        check("blow index", 32'(idx), 32'(fuse_blow_index));
        repeat (BLOW + 4) @(posedge pclk);
    endtask

    // program word that must leave the switch open
    task refuse(input logic [1:0] par, input logic [7:0] val);
        prog.send_word(fppr_pkg::FN_PROGRAM, par, val);
        @(negedge pclk);
        check("blow refused", 32'h0, 32'(fuse_blow_en));
    endtask

    // read mode: eight bits msb first, eighth pulse ends it
    task read_param(input logic [1:0] par, input logic [7:0] exp);
        int i;
        prog.send_word(fppr_pkg::FN_READ, par, 8'hFF);
        for (i = 7; i >= 0; i--) begin
            @(negedge pclk);
            check("pin enable", 32'h0, 32'(filter_readback_oe_n));
            check("pin bit", 32'(exp[i]), 32'(filter_readback_pin));
            check("amp bit", 32'(exp[i]), 32'(amp_digital_bit));
            check("amp enable", 32'h1, 32'(amp_digital_en));
            prog.pulse(1'b0);
        end
        @(negedge pclk);
        check("pin released", 32'h1, 32'(filter_readback_oe_n));
        check("amp digital", 32'h0, 32'(amp_digital_en));
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and simulation registers
        rd(fppr_pkg::REG_STATUS, 32'h0, 1'b0);
        rd(fppr_pkg::REG_FUSES, 32'h0, 1'b0);
        wr(fppr_pkg::REG_SIM_GAIN2, 32'h3);
        rd(fppr_pkg::REG_ACTIVE, 32'h3, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        $display("test reset done");
        // one fuse, no effect while unlocked
        blow(fppr_pkg::PAR_GAIN2, 8'h02, 5'h01);
        rd(fppr_pkg::REG_FUSES, 32'h2, 1'b0);
        rd(fppr_pkg::REG_ACTIVE, 32'h3, 1'b0);
        prog.glitch;
        @(negedge pclk);
        check("blow kept", 32'h1, 32'(fuse_blow_en));
        prog.pulse(1'b1);
        @(negedge pclk);
        check("blow broken", 32'h0, 32'(fuse_blow_en));
        refuse(fppr_pkg::PAR_GAIN2, 8'h05);
        refuse(fppr_pkg::PAR_GAIN2, 8'h08);
        refuse(fppr_pkg::PAR_OTHER, 8'h02);
        $display("test program done");
        read_param(fppr_pkg::PAR_GAIN2, 8'h02);
        $display("test read done");
        // check fuse then lock fuse
        blow(fppr_pkg::PAR_OTHER, 8'h04, 5'h13);
        rd(fppr_pkg::REG_STATUS, 32'h4A, 1'b0);
        check("force low", 32'h0, 32'(amp_force_low));
        blow(fppr_pkg::PAR_OTHER, 8'h01, 5'h12);
        refuse(fppr_pkg::PAR_GAIN1, 8'h01);
        rd(fppr_pkg::REG_STATUS, 32'h07, 1'b0);
        rd(fppr_pkg::REG_ACTIVE, 32'h2, 1'b0);
        wr(fppr_pkg::REG_SIM_GAIN2, 32'h5);
        rd(fppr_pkg::REG_ACTIVE, 32'h2, 1'b0);
        rd(fppr_pkg::REG_SIM_GAIN2, 32'h3, 1'b0);
        // stored bit flips: parity error
        prog.corrupt(10);
        rd(fppr_pkg::REG_STATUS, 32'h1B, 1'b0);
        rd(fppr_pkg::REG_ACTIVE, 32'h402, 1'b0);
        check("force low", 32'h1, 32'(amp_force_low));
        check("perr port", 32'h1, 32'(parity_error));
        check("active port", 32'h402, 32'(active_codes));
        $display("test parity done");
        read_param(fppr_pkg::PAR_OFFSET, 8'h01);
        read_param(fppr_pkg::PAR_OTHER, 8'h05);
        $display("test readback done");
        print_verdict;
    end
endmodule
